// ---- ssu_ext_master.sv ----
// Purpose: External synchronous master that clocks the slave serial unit
// Assumes: Leading edge is rising (polarity bit clear), 64 ns bit clock
// Notes: Clock stands low between frames; data line flips when released
`timescale 1ns/1ps
module ssu_ext_master (
  output logic ck_out,
  output logic dt_out,
  input wire logic dt_in
);
  initial begin
    ck_out = 1'b0;
    dt_out = 1'b0;
  end
  // -------------------------------------------------
  // One character, LSB first, one bit per clock
  // -------------------------------------------------
  task automatic xfer(input int nbits, input logic [8:0] tx, output logic [8:0] rx);
    rx = 9'h000;
    #1.3;
    for (int i = 0; i < nbits; i++) begin
      ck_out = 1'b1;
      dt_out = tx[i];
      #32;
      rx[i] = dt_in;
      ck_out = 1'b0;
      #32;
    end
    dt_out = ~dt_out;
  endtask
endmodule

// ---- ssu_pkg.sv ----
// Purpose: Constants and types for the synchronous slave serial unit
// Assumes: 3-bit register address, 8-bit data
// Notes: Register offsets are local choices
package ssu_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [2:0] ADDR_TXSTA = 3'h0;
  localparam logic [2:0] ADDR_RCSTA = 3'h1;
  localparam logic [2:0] ADDR_TRANSMIT_HOLDING_REGISTER = 3'h2;
  localparam logic [2:0] ADDR_RECEIVE_DATA_REGISTER = 3'h3;
  localparam logic [2:0] ADDR_BAUD = 3'h4;
  localparam logic [2:0] ADDR_BRGL = 3'h5;
  localparam logic [2:0] ADDR_BRGH = 3'h6;
  localparam logic [2:0] ADDR_IEN = 3'h7;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int TX_CLOCK_SOURCE_SELECT = 7;
  localparam int TX_NINE = 6;
  localparam int TX_EN = 5;
  localparam int TX_SYNC = 4;
  localparam int TX_TRMT = 1;
  localparam int TX_NINTH = 0;
  localparam int RC_SERIAL_PORT_ENABLE = 7;
  localparam int RC_NINE = 6;
  localparam int RC_SINGLE_RECEIVE_ENABLE = 5;
  localparam int RC_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int RC_OVERRUN_ERROR_FLAG = 1;
  localparam int RC_NINTH = 0;
  localparam int BD_IDLE = 6;
  localparam int BD_POL = 4;
  localparam int IE_GIE = 7;
  localparam int IE_PERIPHERAL_INTERRUPT_ENABLE = 6;
  localparam int IE_RECEIVE_INTERRUPT_ENABLE = 5;
  localparam int IE_TRANSMIT_INTERRUPT_ENABLE = 4;
  localparam int IE_RECEIVE_FLAG = 1;
  localparam int IE_TRANSMIT_BUFFER_FLAG = 0;
  // ----------------------------------------
  // Write masks, reset values, counts
  // ----------------------------------------
  localparam logic [7:0] TXSTA_WMASK = 8'hF1;
  localparam logic [7:0] RCSTA_WMASK = 8'hF0;
  localparam logic [7:0] BAUD_WMASK = 8'h10;
  localparam logic [7:0] IEN_WMASK = 8'hF0;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [3:0] CHAR_BITS8 = 4'h8;
  localparam logic [3:0] CHAR_BITS9 = 4'h9;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
  typedef struct packed {
    logic ninth;
    logic [7:0] data;
  } ssu_char_t;
endpackage

// ---- ssu_slave.sv ----
// Purpose: Synchronous slave serial unit, transmit and receive
// Assumes: External master drives the bit clock; ck_in, dt_in asynchronous
// Notes: Core clock oversamples the link clock to find its edges
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module ssu_slave
  import ssu_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic sleep_in,
  input wire logic ck_in,
  input wire logic dt_in,
  output logic ck_out,
  output logic ck_oe_out,
  output logic dt_out,
  output logic dt_oe_out,
  output logic wake_out,
  output logic irq_out
);
  function automatic logic hit(input logic [2:0] a, input logic s, input logic [2:0] r);
    hit = s && (a == r);
  endfunction

  logic [7:0] txsta_r, rcsta_r, baud_r, brgl_r, brgh_r, ien_r;
  logic ck_s1_r, ck_s2_r, ck_s3_r, dt_s1_r, dt_s2_r;
  logic serial_port_enable, en, txm, rxm, continuous_receive_enable, lead, trail;
  logic [3:0] tx_bits, rx_bits;
  ssu_char_t transmit_holding_register_r;
  logic transmit_holding_register_full_r, tsr_full_r;
  logic [8:0] tsr_r;
  logic [3:0] tx_cnt_r;
  logic load;
  logic [8:0] rsr_r, rsr_nxt;
  logic [3:0] rx_cnt_r;
  ssu_char_t fifo_r [0:1];
  ssu_char_t rx_char;
  logic [1:0] count_r;
  logic overrun_error_flag_r, done, pop, full_now, push, ovf;
  logic receive_flag, transmit_buffer_flag, ev_tx, ev_rx;
  logic dt_r, dt_oe_r;

  // ----------------------------------------
  // Link input synchronisers
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      ck_s3_r <= 1'b0;
      dt_s1_r <= 1'b0;
      dt_s2_r <= 1'b0;
    end else begin
      ck_s1_r <= ck_in;
      ck_s2_r <= ck_s1_r;
      ck_s3_r <= ck_s2_r;
      dt_s1_r <= dt_in;
      dt_s2_r <= dt_s1_r;
    end
  end

  // Leading and trailing edges after polarity select
  assign lead = (ck_s2_r ^ baud_r[BD_POL]) && !(ck_s3_r ^ baud_r[BD_POL]);
  assign trail = !(ck_s2_r ^ baud_r[BD_POL]) && (ck_s3_r ^ baud_r[BD_POL]);

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  assign serial_port_enable = rcsta_r[RC_SERIAL_PORT_ENABLE];
  assign continuous_receive_enable = rcsta_r[RC_CONTINUOUS_RECEIVE_ENABLE];
  // Shifting keeps running while asleep; no term here depends on sleep_in
  assign en = serial_port_enable && txsta_r[TX_SYNC] && !txsta_r[TX_CLOCK_SOURCE_SELECT];
  // Shifting out also needs transmit enable; clearing it abandons the character
  assign txm = en && txsta_r[TX_EN] && !rcsta_r[RC_SINGLE_RECEIVE_ENABLE] && !continuous_receive_enable;
  assign rxm = en && (rcsta_r[RC_SINGLE_RECEIVE_ENABLE] || continuous_receive_enable);
  assign tx_bits = txsta_r[TX_NINE] ? CHAR_BITS9 : CHAR_BITS8;
  assign rx_bits = rcsta_r[RC_NINE] ? CHAR_BITS9 : CHAR_BITS8;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      txsta_r <= REG_RST;
      rcsta_r <= REG_RST;
      baud_r <= REG_RST;
      brgl_r <= REG_RST;
      brgh_r <= REG_RST;
      ien_r <= REG_RST;
    end else begin
      if (hit(addr_in, wr_in, ADDR_TXSTA)) begin
        txsta_r <= wdata_in & TXSTA_WMASK;
      end
      if (hit(addr_in, wr_in, ADDR_RCSTA)) begin
        rcsta_r <= wdata_in & RCSTA_WMASK;
      end
      if (hit(addr_in, wr_in, ADDR_BAUD)) begin
        baud_r <= wdata_in & BAUD_WMASK;
      end
      if (hit(addr_in, wr_in, ADDR_BRGL)) begin
        brgl_r <= wdata_in;
      end
      if (hit(addr_in, wr_in, ADDR_BRGH)) begin
        brgh_r <= wdata_in;
      end
      if (hit(addr_in, wr_in, ADDR_IEN)) begin
        ien_r <= wdata_in & IEN_WMASK;
      end
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  // Held character moves on whenever in transmit mode (txm) and the shift register is empty
  assign load = txm && transmit_holding_register_full_r && !tsr_full_r;
  assign transmit_buffer_flag = !transmit_holding_register_full_r;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in || !serial_port_enable) begin
      transmit_holding_register_r <= '0;
      transmit_holding_register_full_r <= 1'b0;
      tsr_r <= '0;
      tsr_full_r <= 1'b0;
      tx_cnt_r <= '0;
    end else begin
      if (hit(addr_in, wr_in, ADDR_TRANSMIT_HOLDING_REGISTER)) begin
        transmit_holding_register_r <= '{ninth: txsta_r[TX_NINTH], data: wdata_in};
        transmit_holding_register_full_r <= 1'b1;
      end else if (load) begin
        transmit_holding_register_full_r <= 1'b0;
      end
      if (load) begin
        tsr_r <= transmit_holding_register_r;
        tsr_full_r <= 1'b1;
        tx_cnt_r <= '0;
      end else if (tsr_full_r && !txm) begin
        tsr_full_r <= 1'b0;
      end else if (tsr_full_r && trail) begin
        tsr_r <= tsr_r >> 1;
        tx_cnt_r <= tx_cnt_r + 4'h1;
        if (tx_cnt_r == tx_bits - 4'h1) begin
          tsr_full_r <= 1'b0;
        end
      end
    end
  end

  // Data changes on the leading edge, master samples on the trailing one
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      dt_r <= 1'b0;
      dt_oe_r <= 1'b0;
    end else begin
      dt_oe_r <= txm;
      if (tsr_full_r && lead) begin
        dt_r <= tsr_r[0];
      end
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  assign rsr_nxt = {dt_s2_r, rsr_r[8:1]};
  assign rx_char.ninth = rcsta_r[RC_NINE] ? rsr_nxt[8] : 1'b0;
  assign rx_char.data = rcsta_r[RC_NINE] ? rsr_nxt[7:0] : rsr_nxt[8:1];
  assign done = rxm && !overrun_error_flag_r && trail && (rx_cnt_r == rx_bits - 4'h1);
  assign pop = hit(addr_in, rd_in, ADDR_RECEIVE_DATA_REGISTER) && (count_r != 2'h0);
  assign full_now = (count_r == FIFO_DEPTH) && !pop;
  assign push = done && !full_now;
  assign ovf = done && full_now;
  assign receive_flag = (count_r != 2'h0);

  always_ff @(posedge clk_in) begin
    if (!rst_b_in || !serial_port_enable) begin
      rsr_r <= '0;
      rx_cnt_r <= '0;
    end else if (!rxm || overrun_error_flag_r) begin
      rx_cnt_r <= '0;
    end else if (trail) begin
      // Never goes idle and never self-stops after one character
      rsr_r <= rsr_nxt;
      rx_cnt_r <= done ? 4'h0 : rx_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in || !serial_port_enable) begin
      fifo_r[0] <= '0;
      fifo_r[1] <= '0;
      count_r <= '0;
    end else begin
      case ({push, pop})
        2'b10: begin
          fifo_r[count_r[0]] <= rx_char;
          count_r <= count_r + 2'h1;
        end
        2'b01: begin
          fifo_r[0] <= fifo_r[1];
          count_r <= count_r - 2'h1;
        end
        2'b11: begin
          if (count_r == 2'h1) begin
            fifo_r[0] <= rx_char;
          end else begin
            fifo_r[0] <= fifo_r[1];
            fifo_r[1] <= rx_char;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Overrun: a new overrun wins over a clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || !serial_port_enable) begin
      overrun_error_flag_r <= 1'b0;
    end else if (ovf) begin
      overrun_error_flag_r <= 1'b1;
    end else if (!(rcsta_r[RC_SINGLE_RECEIVE_ENABLE] || continuous_receive_enable)) begin
      // Either enable keeps reception continuous in slave mode, so both must drop
      overrun_error_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Wake and interrupt request
  // ----------------------------------------
  assign ev_tx = ien_r[IE_PERIPHERAL_INTERRUPT_ENABLE] && ien_r[IE_TRANSMIT_INTERRUPT_ENABLE] && transmit_buffer_flag;
  assign ev_rx = ien_r[IE_RECEIVE_INTERRUPT_ENABLE] && receive_flag;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      wake_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      wake_out <= sleep_in && (ev_tx || ev_rx);
      irq_out <= ien_r[IE_GIE] && (ev_tx || ev_rx);
    end
  end

  // ----------------------------------------
  // Read port and pins
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rdata_out <= REG_RST;
    end else if (!rd_in) begin
      rdata_out <= REG_RST;
    end else if (addr_in == ADDR_TXSTA) begin
      rdata_out <= txsta_r | {6'h00, !tsr_full_r, 1'b0};
    end else if (addr_in == ADDR_RCSTA) begin
      rdata_out <= {rcsta_r[7:4], 2'h0, overrun_error_flag_r, fifo_r[0].ninth};
    end else if (addr_in == ADDR_RECEIVE_DATA_REGISTER) begin
      rdata_out <= fifo_r[0].data;
    end else if (addr_in == ADDR_BAUD) begin
      rdata_out <= baud_r | {1'b0, (rx_cnt_r == 4'h0), 6'h00};
    end else if (addr_in == ADDR_BRGL) begin
      rdata_out <= brgl_r;
    end else if (addr_in == ADDR_BRGH) begin
      rdata_out <= brgh_r;
    end else if (addr_in == ADDR_IEN) begin
      rdata_out <= ien_r | {6'h00, receive_flag, transmit_buffer_flag};
    end else begin
      rdata_out <= REG_RST;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ck_out <= 1'b0;
      ck_oe_out <= 1'b0;
    end else begin
      ck_out <= 1'b0;
      ck_oe_out <= 1'b0;
    end
  end

  assign dt_out = dt_r;
  assign dt_oe_out = dt_oe_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  AST_TX_LOAD: assert property (load |=> tsr_full_r && tx_cnt_r == 4'h0)
    else $error("held character not moved to shift register");
  AST_TX_REFILL: assert property ($fell(tsr_full_r) && transmit_holding_register_full_r && txm
    |=> !transmit_holding_register_full_r && tsr_full_r)
    else $error("held character not loaded after shift-out");
  AST_TX_MODE: assert property (txm |=> dt_oe_out)
    else $error("data line not driven in transmit mode");
  AST_RX_FLAG: assert property (done && count_r == 2'h0 && !pop |=> receive_flag)
    else $error("receive flag not set on complete character");
  AST_OVERRUN: assert property (ovf |=> overrun_error_flag_r && count_r == FIFO_DEPTH)
    else $error("overrun not flagged or buffer changed");
  AST_OVR_CLEAR: assert property (overrun_error_flag_r && !(rcsta_r[RC_SINGLE_RECEIVE_ENABLE] || continuous_receive_enable) && !ovf && serial_port_enable
    |=> !overrun_error_flag_r)
    else $error("overrun not cleared by dropping continuous receive");
  AST_PORT_RESET: assert property (!serial_port_enable |=> count_r == 2'h0 && !tsr_full_r
    && !transmit_holding_register_full_r && !overrun_error_flag_r)
    else $error("port disable did not reset the unit");
  AST_WAKE: assert property (sleep_in && ev_rx |=> wake_out)
    else $error("received character did not wake");
  AST_CK_OFF: assert property (ck_oe_out == 1'b0)
    else $error("clock line driven in slave mode");
endmodule

// ---- ssu_slave_test.sv ----
// Purpose: Self-checking bench for the synchronous slave serial unit
// Assumes: Register port with one-cycle read latency
// Notes: Link traffic comes from the external master model
`timescale 1ns/1ps
module ssu_slave_test;
  import ssu_pkg::*;
  logic clk_in, rst_b_in, wr_in, rd_in, sleep_in;
  logic [2:0] addr_in;
  logic [7:0] wdata_in, rdata_out, d;
  logic ck_out, ck_oe_out, dt_out, dt_oe_out, wake_out, irq_out;
  logic m_ck, m_dt, ck_w, dt_w;
  logic [8:0] rx;
  int failures, n_compared;
  assign ck_w = ck_oe_out ? ck_out : m_ck;
  assign dt_w = dt_oe_out ? dt_out : m_dt;
  ssu_slave i_ssu_slave (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .sleep_in(sleep_in), .ck_in(ck_w), .dt_in(dt_w), .ck_out(ck_out),
    .ck_oe_out(ck_oe_out), .dt_out(dt_out), .dt_oe_out(dt_oe_out),
    .wake_out(wake_out), .irq_out(irq_out));
  ssu_ext_master i_ssu_ext_master (.ck_out(m_ck), .dt_out(m_dt), .dt_in(dt_w));
  // -------------------------------------------------
  // Bus, link and compare helpers
  // -------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic settle;
    repeat (8) @(posedge clk_in);
    #1;
  endtask
  task automatic link(input int n, input logic [8:0] v);
    i_ssu_ext_master.xfer(n, v, rx);
    settle();
  endtask
  task automatic complete_run;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  initial begin
    #100000;
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
  // -------------------------------------------------
  // Test sequence
  // -------------------------------------------------
  initial begin
    rst_b_in = 1'b0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 3'h0;
    wdata_in = 8'h00;
    sleep_in = 1'b0;
    repeat (10) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rd(ADDR_RCSTA); chk(d, REG_RST, "rcsta reset");
    rd(ADDR_IEN); chk(d, 8'h01, "ien reset, tx buffer empty");
    chk(ck_oe_out, 1'b0, "clock driver off");
    $display("test reset done");
    wr(ADDR_TXSTA, 8'h30);
    wr(ADDR_RCSTA, 8'h80);
    wr(ADDR_IEN, 8'h50);
    wr(ADDR_TRANSMIT_HOLDING_REGISTER, 8'hA5);
    wr(ADDR_TRANSMIT_HOLDING_REGISTER, 8'h3C);
    sleep_in <= 1'b1;
    rd(ADDR_IEN); chk(d[IE_TRANSMIT_BUFFER_FLAG], 1'b0, "tx flag held clear");
    chk(dt_oe_out, 1'b1, "transmit drives data");
    chk(wake_out, 1'b0, "no early wake");
    link(8, 9'h000); chk(rx, 9'h0A5, "tx char 1");
    chk(wake_out, 1'b1, "tx wake");
    chk(irq_out, 1'b0, "no irq without global enable");
    chk(ck_oe_out, 1'b0, "clock driver off in tx");
    wr(ADDR_IEN, 8'hD0);
    settle(); chk(irq_out, 1'b1, "tx irq");
    rd(ADDR_IEN); chk(d[IE_TRANSMIT_BUFFER_FLAG], 1'b1, "tx flag set");
    link(8, 9'h000); chk(rx, 9'h03C, "tx char 2");
    sleep_in <= 1'b0;
    wr(ADDR_TXSTA, 8'h71);
    wr(ADDR_TRANSMIT_HOLDING_REGISTER, 8'h5A);
    link(9, 9'h000); chk(rx, 9'h15A, "tx nine bits");
    $display("test transmit done");
    wr(ADDR_IEN, 8'h20);
    wr(ADDR_RCSTA, 8'hA0);
    sleep_in <= 1'b1;
    link(8, 9'h011);
    chk(dt_oe_out, 1'b0, "receive releases data");
    chk(wake_out, 1'b1, "rx wake");
    rd(ADDR_IEN); chk(d[IE_RECEIVE_FLAG], 1'b1, "rx flag");
    rd(ADDR_RCSTA); chk(d[RC_SINGLE_RECEIVE_ENABLE], 1'b1, "single enable kept");
    link(8, 9'h022);
    link(8, 9'h033);
    rd(ADDR_RCSTA); chk(d[RC_OVERRUN_ERROR_FLAG], 1'b1, "overrun");
    link(8, 9'h044);
    rd(ADDR_RECEIVE_DATA_REGISTER); chk(d, 8'h11, "fifo head");
    rd(ADDR_RECEIVE_DATA_REGISTER); chk(d, 8'h22, "fifo second");
    rd(ADDR_IEN); chk(d[IE_RECEIVE_FLAG], 1'b0, "no char after overrun");
    wr(ADDR_RCSTA, 8'h00);
    wr(ADDR_RCSTA, 8'h90);
    rd(ADDR_RCSTA); chk(d[RC_OVERRUN_ERROR_FLAG], 1'b0, "overrun cleared");
    wr(ADDR_RCSTA, 8'hD0);
    link(9, 9'h1C3);
    rd(ADDR_RCSTA); chk(d[RC_NINTH], 1'b1, "rx ninth bit");
    rd(ADDR_RECEIVE_DATA_REGISTER); chk(d, 8'hC3, "rx low byte");
    $display("test receive done");
    complete_run();
  end
endmodule
